// file: lcm_map.svh
`ifndef LCM_MAP_SVH
`define LCM_MAP_SVH

// Register offsets on the device's internal register port.
`define LCM_OFS_SEL 8'h21
`define LCM_OFS_RESULT 8'h22
`define LCM_OFS_MASK 8'h2E

// Field positions in the selector register.
`define LCM_SEL_HI_MSB 6
`define LCM_SEL_HI_LSB 4
`define LCM_SEL_RSV_HI 7
`define LCM_SEL_RSV_LO 3

// Mask bit positions.
`define LCM_MASK_READY 3
`define LCM_MASK_SUPPLY 2
`define LCM_MASK_THERMAL 1
`define LCM_MASK_HEAT 0

// Reset values.
`define LCM_SEL_RST 3'h0
`define LCM_RESULT_RST 11'h000
`define LCM_MASK_RST 8'h0B

// Source codes and core count.
`define LCM_NUM_CORES 6
`define LCM_SRC_TOTAL 3'h6

// Scaling and saturation.
`define LCM_MA_PER_LSB 32'h0000_000A
`define LCM_SAT_MA 32'h0000_4FF6
`define LCM_CODE_MAX 11'h7FF

// Averaging window.
`define LCM_CLK_HZ 32'h0098_9680
`define LCM_AVG_WIN_MS 32'h0000_0005
`define LCM_AVG_CYCLES (`LCM_AVG_WIN_MS * `LCM_CLK_HZ / 32'h0000_03E8)

`endif

// file: lcm_pkg.sv
package lcm_pkg;
   typedef logic [2:0] lcm_sel_t;
   typedef logic [10:0] lcm_code_t;
   typedef logic [15:0] lcm_core_t;
   typedef logic [18:0] lcm_sample_t;
endpackage

// file: lcm_avg.sv
`timescale 1ns/1ns
`default_nettype none
`include "lcm_map.svh"

module lcm_avg #(
   parameter int unsigned WIN = `LCM_AVG_CYCLES
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic ce,
   input wire logic restart,
   input wire lcm_pkg::lcm_sample_t sample,
   output lcm_pkg::lcm_code_t code_q,
   output logic done_q
);
   logic [31:0] cnt_q;
   logic [31:0] cnt_d;
   logic [39:0] acc_q;
   logic [39:0] acc_d;
   lcm_pkg::lcm_code_t code_d;
   logic done_d;
   // The sum is 40 bits wide so a full window of the largest total cannot wrap.
   logic [39:0] sum;
   logic [39:0] avg;
   logic [39:0] lsb;

   // Sum one sample a cycle and close the window with a rounded-down mean.
   always_comb begin
      cnt_d = cnt_q;
      acc_d = acc_q;
      code_d = code_q;
      done_d = 1'b0;
      sum = acc_q + {21'h00_0000, sample};
      avg = 40'h00_0000_0000;
      lsb = 40'h00_0000_0000;
      if (restart) begin
         cnt_d = 32'h0000_0000;
         acc_d = 40'h00_0000_0000;
      end else if (cnt_q == WIN - 1) begin
         avg = sum / WIN;
         lsb = avg / `LCM_MA_PER_LSB;
         if (avg >= `LCM_SAT_MA) begin
            code_d = `LCM_CODE_MAX;
         end else begin
            code_d = lsb[10:0];
         end
         cnt_d = 32'h0000_0000;
         acc_d = 40'h00_0000_0000;
         done_d = 1'b1;
      end else begin
         cnt_d = cnt_q + 32'h0000_0001;
         acc_d = sum;
      end
   end

   // Reset clears the reported code whatever the enable does.
   always_ff @(posedge clk) begin
      if (srst) begin
         cnt_q <= 32'h0000_0000;
         acc_q <= 40'h00_0000_0000;
         code_q <= `LCM_RESULT_RST;
         done_q <= 1'b0;
      end else if (ce) begin
         cnt_q <= cnt_d;
         acc_q <= acc_d;
         code_q <= code_d;
         done_q <= done_d;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   // A strobe taken on an enabled edge means the last cycle closed a window.
   a_code_ceiling: assert property (
      done_q && $past(ce) && $past(avg) >= `LCM_SAT_MA
      |-> code_q == `LCM_CODE_MAX)
      else $error("saturated average did not read all ones");
   a_code_floor: assert property (
      done_q && $past(ce) && $past(avg) < `LCM_MA_PER_LSB
      |-> code_q == 11'h000)
      else $error("average below one step did not read zero");
endmodule
`default_nettype wire

// file: lcm_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "lcm_map.svh"

module lcm_top #(
   parameter int unsigned AVG_CYCLES = `LCM_AVG_CYCLES
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic ce,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire lcm_pkg::lcm_core_t core_ma [`LCM_NUM_CORES],
   input wire logic meter_ready_flag,
   input wire logic supply_low_lockout_flag,
   input wire logic thermal_warn_flag,
   input wire logic [1:0] die_heat_level,
   output lcm_pkg::lcm_sel_t meter_source,
   output lcm_pkg::lcm_code_t meter_result_value,
   output logic meter_done,
   output logic irq_request
);
   lcm_pkg::lcm_sel_t sel_q;
   lcm_pkg::lcm_sel_t sel_d;
   logic [1:0] rsv_q;
   logic [1:0] rsv_d;
   logic [7:0] mask_q;
   logic [7:0] mask_d;
   logic [7:0] rdata_q;
   logic [7:0] rdata_d;
   logic [1:0] heat_q;
   logic [1:0] heat_d;
   logic irq_q;
   logic irq_d;
   logic restart;
   lcm_pkg::lcm_sample_t psum [`LCM_NUM_CORES + 1];
   lcm_pkg::lcm_sample_t sample;
   lcm_pkg::lcm_code_t result;
   logic done;

   // Running sum of all cores gives the combined total.
   assign psum[0] = 19'h0_0000;
   for (genvar i = 0; i < `LCM_NUM_CORES; i++) begin : g_total
      assign psum[i + 1] = psum[i] + {3'h0, core_ma[i]};
   end

   // Route the chosen source to the averager.
   always_comb begin
      sample = 19'h0_0000;
      if (sel_q < 3'(`LCM_NUM_CORES)) begin
         sample = {3'h0, core_ma[sel_q]};
      end else if (sel_q == `LCM_SRC_TOTAL) begin
         sample = psum[`LCM_NUM_CORES];
      end
   end

   // The averager owns the result register, so both halves share one window.
   lcm_avg #(
      .WIN(AVG_CYCLES)
   ) lcm_avg_inst (
      .clk(clk),
      .srst(srst),
      .ce(ce),
      .restart(restart),
      .sample(sample),
      .code_q(result),
      .done_q(done)
   );

   // Register writes and the registered read answer.
   always_comb begin
      sel_d = sel_q;
      rsv_d = rsv_q;
      mask_d = mask_q;
      rdata_d = rdata_q;
      restart = 1'b0;
      if (reg_wr) begin
         unique case (reg_addr)
            `LCM_OFS_SEL: begin
               sel_d = reg_wdata[2:0];
               rsv_d = {reg_wdata[`LCM_SEL_RSV_HI],
                        reg_wdata[`LCM_SEL_RSV_LO]};
               restart = (reg_wdata[2:0] != sel_q);
            end
            `LCM_OFS_MASK: begin
               mask_d = reg_wdata;
            end
            default: begin
               sel_d = sel_q;
            end
         endcase
      end
      if (reg_rd) begin
         unique case (reg_addr)
            `LCM_OFS_SEL: begin
               rdata_d = {rsv_q[1], result[10:8], rsv_q[0], sel_q};
            end
            `LCM_OFS_RESULT: begin
               rdata_d = result[7:0];
            end
            `LCM_OFS_MASK: begin
               rdata_d = mask_q;
            end
            default: begin
               rdata_d = 8'h00;
            end
         endcase
      end
   end

   // Registers move only while enabled; reset acts regardless.
   always_ff @(posedge clk) begin
      if (srst) begin
         sel_q <= `LCM_SEL_RST;
         rsv_q <= 2'h0;
         mask_q <= `LCM_MASK_RST;
         rdata_q <= 8'h00;
      end else if (ce) begin
         sel_q <= sel_d;
         rsv_q <= rsv_d;
         mask_q <= mask_d;
         rdata_q <= rdata_d;
      end
   end

   // Combine unmasked flag sources into one interrupt request.
   always_comb begin
      heat_d = die_heat_level;
      irq_d = (meter_ready_flag && !mask_q[`LCM_MASK_READY]) ||
         (supply_low_lockout_flag && !mask_q[`LCM_MASK_SUPPLY]) ||
         (thermal_warn_flag && !mask_q[`LCM_MASK_THERMAL]) ||
         ((die_heat_level != heat_q) && !mask_q[`LCM_MASK_HEAT]);
   end

   // The heat copy and the request are registered together.
   always_ff @(posedge clk) begin
      if (srst) begin
         heat_q <= 2'h0;
         irq_q <= 1'b0;
      end else if (ce) begin
         heat_q <= heat_d;
         irq_q <= irq_d;
      end
   end

   // Every output comes straight from a register.
   assign reg_rdata = rdata_q;
   assign meter_source = sel_q;
   assign meter_result_value = result;
   assign meter_done = done;
   assign irq_request = irq_q;

   // Checks on the register port, the result and the interrupt masks.
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   a_sel_write: assert property (
      ce && reg_wr && reg_addr == `LCM_OFS_SEL
      |=> sel_q == $past(reg_wdata[2:0]))
      else $error("selector did not take the written code");
   a_hi_readback: assert property (
      ce && reg_rd && reg_addr == `LCM_OFS_SEL
      |=> reg_rdata[6:4] == $past(result[10:8])
      && reg_rdata[2:0] == $past(sel_q))
      else $error("selector read lost result upper bits");
   a_lo_readback: assert property (
      ce && reg_rd && reg_addr == `LCM_OFS_RESULT
      |=> reg_rdata == $past(result[7:0]))
      else $error("result read did not return lower bits");
   a_result_reset: assert property (
      disable iff (1'b0) $past(srst)
      |-> result == 11'h000 && mask_q == `LCM_MASK_RST && sel_q == 3'h0)
      else $error("reset did not clear result and controls");
   a_result_atomic: assert property (
      !$stable(result) |-> $past(done) || done)
      else $error("result changed without a finished window");
   a_wr_ignored: assert property (
      ce && reg_wr && reg_addr == `LCM_OFS_RESULT
      |=> $stable(mask_q) && $stable(sel_q))
      else $error("write to result register had an effect");
   a_mask_write: assert property (
      ce && reg_wr && reg_addr == `LCM_OFS_MASK
      |=> mask_q == $past(reg_wdata))
      else $error("mask register did not take the written byte");
   a_ready_mask: assert property (
      ce && meter_ready_flag && !mask_q[3]
      |=> irq_request)
      else $error("unmasked ready flag gave no interrupt");
   a_supply_mask: assert property (
      ce && supply_low_lockout_flag && !mask_q[2]
      |=> irq_request)
      else $error("unmasked supply-low flag gave no interrupt");
   a_thermal_mask: assert property (
      ce && thermal_warn_flag && !mask_q[1]
      |=> irq_request)
      else $error("unmasked thermal flag gave no interrupt");
   a_heat_change: assert property (
      ce && die_heat_level != heat_q && !mask_q[0]
      |=> irq_request)
      else $error("unmasked heat change gave no interrupt");
   a_all_masked: assert property (
      ce && mask_q[3:0] == 4'hF
      |=> !irq_request)
      else $error("interrupt raised while every source was masked");
   a_done_pulse: assert property (
      ce && done |=> !done)
      else $error("result strobe lasted longer than one cycle");
endmodule
`default_nettype wire

// file: lcm_host.sv
`timescale 1ns/1ns
`default_nettype none
// Host side of the register port: one taken edge per request.
module lcm_host (
   input wire logic clk,
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata,
   output logic reg_wr,
   output logic reg_rd,
   input wire logic [7:0] reg_rdata
);
   // The port is idle at time zero.
   initial begin
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end

   // A write holds address and data through its single taken edge.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      reg_wdata <= ~d;  // Stale data must not look valid.
   endtask

   // A read samples the answer one cycle after its taken edge.
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(posedge clk);
      #1;
      d = reg_rdata;
   endtask
endmodule
`default_nettype wire

// file: tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "lcm_map.svh"
module tb_top;
   localparam int N = 8;
   localparam int MA [6] = '{9, 10, 20469, 20470, 500, 200};
   logic clk, srst, ce, reg_wr, reg_rd, meter_done, irq_request;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, rv;
   logic meter_ready_flag, supply_low_lockout_flag, thermal_warn_flag;
   logic [1:0] die_heat_level;
   lcm_pkg::lcm_core_t core_ma [`LCM_NUM_CORES];
   lcm_pkg::lcm_sel_t meter_source;
   lcm_pkg::lcm_code_t meter_result_value, e;
   int err_count, check_count, sum;

   lcm_top #(.AVG_CYCLES(N)) lcm_top_inst (.clk(clk), .srst(srst),
      .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .core_ma(core_ma), .meter_ready_flag(meter_ready_flag),
      .supply_low_lockout_flag(supply_low_lockout_flag),
      .thermal_warn_flag(thermal_warn_flag),
      .die_heat_level(die_heat_level), .meter_source(meter_source),
      .meter_result_value(meter_result_value), .meter_done(meter_done),
      .irq_request(irq_request));
   lcm_host lcm_host_inst (.clk(clk), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata));

   // The clock runs at 10 MHz.
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // Core 5 alternates 100 and 300 mA, so every window averages 200 mA.
   always @(posedge clk) begin
      core_ma[5] <= (core_ma[5] == 16'h0064) ? 16'h012C : 16'h0064;
   end

   // Expected code: floor of mA over 10, saturating at all ones.
   function automatic lcm_pkg::lcm_code_t exp_code(input int ma);
      return (ma >= 20470) ? 11'h7FF : 11'(ma / 10);
   endfunction

   // Compare tasks count every check and report each mismatch.
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk11(input logic [10:0] got, input logic [10:0] exp);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Prints the verdict and ends the run.
   task automatic results;
      if (err_count == 0 && check_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // Waits for a stored result under a bounded count.
   task automatic wait_done;
      for (int i = 0; i < 40; i++) begin
         @(posedge clk);
         #1;
         if (meter_done === 1'b1) return;
      end
      err_count++;
      results();
   endtask

   // Pulses reset, then reads the result register first, before a window ends.
   task automatic reset_check;
      srst <= 1'b1;
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      lcm_host_inst.rd(8'h22, rv);
      chk8(rv, 8'h00);
      lcm_host_inst.rd(8'h21, rv);
      chk8(rv, 8'h00);
      lcm_host_inst.rd(8'h2E, rv);
      chk8(rv, 8'h0B);
      chk11({10'h000, irq_request}, 11'h000);
   endtask

   // Steps the heat level and counts the request cycles that follow.
   task automatic heat_step(input logic [1:0] v, input logic [10:0] exp);
      int n;
      n = 0;
      @(posedge clk);
      die_heat_level <= v;
      for (int i = 0; i < 4; i++) begin
         @(posedge clk);
         #1;
         if (irq_request === 1'b1) n++;
      end
      chk11(11'(n), exp);
   endtask

   // Main sequence: reset, metering, access kinds, masking, reset again.
   initial begin
      srst = 1'b1;
      ce = 1'b1;
      err_count = 0;
      check_count = 0;
      meter_ready_flag = 1'b0;
      supply_low_lockout_flag = 1'b0;
      thermal_warn_flag = 1'b0;
      die_heat_level = 2'b00;
      sum = 0;
      for (int i = 0; i < 5; i++) begin
         core_ma[i] = 16'(MA[i]);
      end
      core_ma[5] = 16'h0064;
      for (int i = 0; i < 6; i++) begin
         sum += MA[i];
      end
      reset_check();
      for (int s = 0; s < 8; s++) begin
         lcm_host_inst.wr(8'h21, {5'b00000, 3'(s)});
         wait_done();
         wait_done();
         // Code 111 meters nothing, so it must read zero.
         e = exp_code((s == 6) ? sum : (s == 7) ? 0 : MA[s]);
         lcm_host_inst.rd(8'h22, rv);
         chk8(rv, e[7:0]);
         lcm_host_inst.rd(8'h21, rv);
         chk8(rv, {1'b0, e[10:8], 1'b0, 3'(s)});
         chk11(meter_result_value, e);
         chk11({8'h00, meter_source}, 11'(s));
      end
      lcm_host_inst.wr(8'h22, 8'hFF);
      lcm_host_inst.rd(8'h22, rv);
      chk8(rv, 8'h00);
      lcm_host_inst.wr(8'h30, 8'h5A);
      lcm_host_inst.rd(8'h30, rv);
      chk8(rv, 8'h00);
      // A write while the enable is low must not reach the mask.
      @(posedge clk);
      ce <= 1'b0;
      lcm_host_inst.wr(8'h2E, 8'h00);
      ce <= 1'b1;
      lcm_host_inst.rd(8'h2E, rv);
      chk8(rv, 8'h0B);
      lcm_host_inst.wr(8'h2E, 8'hFF);
      @(posedge clk);
      meter_ready_flag <= 1'b1;
      supply_low_lockout_flag <= 1'b1;
      thermal_warn_flag <= 1'b1;
      repeat (3) @(posedge clk);
      #1;
      chk11({10'h000, irq_request}, 11'h000);
      for (int b = 1; b < 4; b++) begin
         lcm_host_inst.wr(8'h2E, 8'hFF ^ (8'h01 << b));
         lcm_host_inst.rd(8'h2E, rv);
         chk8(rv, 8'hFF ^ (8'h01 << b));
         chk11({10'h000, irq_request}, 11'h001);
      end
      lcm_host_inst.wr(8'h2E, 8'hFF);
      heat_step(2'b01, 11'h000);
      lcm_host_inst.wr(8'h2E, 8'hFE);
      heat_step(2'b10, 11'h001);
      @(posedge clk);
      meter_ready_flag <= 1'b0;
      supply_low_lockout_flag <= 1'b0;
      thermal_warn_flag <= 1'b0;
      lcm_host_inst.wr(8'h21, 8'h06);
      wait_done();
      @(posedge clk);
      reset_check();
      // After reset only the supply-low source is unmasked.
      @(posedge clk);
      meter_ready_flag <= 1'b1;
      thermal_warn_flag <= 1'b1;
      repeat (2) @(posedge clk);
      #1;
      chk11({10'h000, irq_request}, 11'h000);
      @(posedge clk);
      supply_low_lockout_flag <= 1'b1;
      repeat (2) @(posedge clk);
      #1;
      chk11({10'h000, irq_request}, 11'h001);
      results();
   end
endmodule
`default_nettype wire
